/* File: shared/bsfl_regs.vh */
/*
 * Constants of the boot strap and flash loader: clock rates, strap level
 * thresholds, dead-battery mode and default configuration codes, flash
 * command and bundle layout.
 * Assumes the strap levels arrive as 8-bit ADC codes, full scale = 1.00.
 */
`ifndef BSFL_REGS_VH
`define BSFL_REGS_VH

// Clock rates in kHz and strap settling time in us
`define BSFL_CLK_KHZ        250000
`define BSFL_SCK_MAX_KHZ    12000
`define BSFL_SETTLE_US      10

// Strap thresholds: 8-bit code of 0.09, 0.19 ... 0.89 of supply
`define BSFL_THR_0          8'h17
`define BSFL_THR_1          8'h31
`define BSFL_THR_2          8'h4a
`define BSFL_THR_3          8'h64
`define BSFL_THR_4          8'h7d
`define BSFL_THR_5          8'h97
`define BSFL_THR_6          8'hb1
`define BSFL_THR_7          8'hca
`define BSFL_THR_8          8'he4

// Dead-battery modes
`define BSFL_DB_NO_RESPONSE 3'h0
`define BSFL_DB_WAIT_INT    3'h1
`define BSFL_DB_WAIT_EXT    3'h2
`define BSFL_DB_CTRL_INT    3'h3
`define BSFL_DB_CTRL_EXT    3'h4
`define BSFL_DB_NO_WAIT     3'h5

// Default device configurations
`define BSFL_CFG_SAFE       3'h0
`define BSFL_CFG_INF_WAIT   3'h1
`define BSFL_CFG_1          3'h2
`define BSFL_CFG_2          3'h3
`define BSFL_CFG_3          3'h4
`define BSFL_CFG_4          3'h5
`define BSFL_CFG_5          3'h6
`define BSFL_CFG_RESERVED   3'h7

// Address code: top bit selects the port
`define BSFL_ADDR_PORT_ONE  1'b0
`define BSFL_ADDR_PORT_TWO  1'b1

// Flash read sequence and bundle layout (byte index within the transfer)
`define BSFL_CMD_READ       8'h03
`define BSFL_IDX_ADDR_HI    8'h01
`define BSFL_IDX_ADDR_MID   8'h02
`define BSFL_IDX_ADDR_LO    8'h03
`define BSFL_IDX_SIG        8'h04
`define BSFL_IDX_SWITCH     8'h05
`define BSFL_SW_INT_BIT     0
`define BSFL_SW_EXT_BIT     1
`define BSFL_SECTOR_BITS    12

`endif

/* File: core/bsfl_spi_master.v */
/*
 * SPI mode 0 byte engine for the flash loader.
 * Assumes start is a one-cycle pulse given only while busy is low and that
 * the flash data line is asynchronous to clk.
 */
`include "bsfl_regs.vh"

module bsfl_spi_master #(
    parameter HALF = 11
) (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Byte request
    input  wire       start,
    input  wire [7:0] txByte,
    input  wire       keepSel,
    output reg        busy,
    output reg        done,
    output reg  [7:0] rxByte,
    output reg        misoSync,
    // Flash pins
    output reg        flashClk,
    output reg        flashCsN,
    output reg        flashDataOut,
    input  wire       flashDataIn
);

    reg  [7:0] cnt_ff;
    reg  [2:0] bit_ff;
    reg  [7:0] sh_ff;
    reg        keep_ff;
    reg        miso_meta_ff;

    // Two flops before anything reads the flash data line
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            miso_meta_ff <= 1'b0;
            misoSync     <= 1'b0;
        end else begin
            miso_meta_ff <= flashDataIn;
            misoSync     <= miso_meta_ff;
        end
    end

    // Bit engine; clock idles low outside transfers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy         <= 1'b0;
            done         <= 1'b0;
            rxByte       <= 8'h00;
            flashClk     <= 1'b0;
            flashCsN     <= 1'b1;
            flashDataOut <= 1'b0;
            cnt_ff       <= 8'h00;
            bit_ff       <= 3'h0;
            sh_ff        <= 8'h00;
            keep_ff      <= 1'b0;
        end else if (!busy) begin
            done     <= 1'b0;
            flashClk <= 1'b0;
            if (start) begin
                busy         <= 1'b1;
                flashCsN     <= 1'b0;
                flashDataOut <= txByte[7];
                sh_ff        <= {txByte[6:0], 1'b0};
                bit_ff       <= 3'h0;
                cnt_ff       <= 8'h00;
                keep_ff      <= keepSel;
            end
        end else if (cnt_ff == HALF[7:0] - 8'h01) begin
            cnt_ff <= 8'h00;
            if (!flashClk) begin
                // Rising edge: capture the flash bit
                flashClk <= 1'b1;
                rxByte   <= {rxByte[6:0], misoSync};
            end else begin
                // Falling edge: next bit goes out only now
                flashClk <= 1'b0;
                if (bit_ff == 3'h7) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    if (!keep_ff)
                        flashCsN <= 1'b1;
                end else begin
                    bit_ff       <= bit_ff + 3'h1;
                    flashDataOut <= sh_ff[7];
                    sh_ff        <= {sh_ff[6:0], 1'b0};
                end
            end
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

endmodule // bsfl_spi_master

/* File: core/bsfl_boot_loader.v */
/*
 * Boot strap decode and flash bundle loader. Latches the address and boot
 * mode straps, applies the dead-battery policy, reads the bundle from the
 * SPI flash and falls back to the strapped default configuration.
 * Assumes strap levels are digitised ADC codes that are steady at boot,
 * and that the flash sits on the SPI pins with its data line pulled up or down by the data strap.
 */
//
// Behaviour
// - Address code from digitised address strap level
// - Four levels give port codes 000-011 / 100-111
// - Boot fetches the bundle from flash
// - Flash link uses SPI mode 0 only
// - First bit out with chip select assertion
// - Chip select low selects, high deselects
// - Shift after falling edge, sample on rising
// - Serial clock idles low between transfers
// - Fast clock through boot, slow clock in low power once booted
// - Power-on boot initialises state then loads bundles
// - Data strap high: six ranges pick mode/default
// - Data strap low: nine ranges pick config/mode
// - Dead-battery mode applies only when bus-powered
// - No-response: no switch, wait for aux supply
// - Wait modes: close switch, wait for supply
// - Controller-wait modes: close switch, retry forever
// - No-wait: load while powered from bus only
// - No-wait: close switch the bundle designates
// - Safe default: ports off, legacy sink on bus
// - Infinite-wait default: stay in boot until loaded
`include "bsfl_regs.vh"

module bsfl_boot_loader #(
    parameter       LOAD_BYTES   = 16,
    parameter [3:0] FLASH_SECTOR = 4'h0,
    parameter [7:0] BUNDLE_SIG   = 8'ha5,   // arbitrary marker value
    parameter       RETRY_CYCLES = 25000
) (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Strap levels from the ADC
    input  wire [7:0] addrStrapLevel,
    input  wire [7:0] bootStrapLevel,
    // Supplies and power state
    input  wire       auxSupplyIn,
    input  wire [1:0] cableBusIn,
    input  wire       lowPowerReq,
    // Flash pins
    output wire       flashClk,
    output wire       flashCsN,
    output wire       flashDataOut,
    input  wire       flashDataIn,
    // Decoded straps
    output reg  [2:0] portOneAddrCode,
    output reg  [2:0] portTwoAddrCode,
    output reg  [2:0] deadBattMode,
    output reg  [2:0] defaultConfig,
    // Boot results
    output reg        bootDone,
    output reg        configLoaded,
    output reg        loadFail,
    output reg        portsEnable,
    output reg        legacySinkEn,
    output reg  [1:0] intSwitchEn,
    output reg  [1:0] extSwitchEn,
    output reg        coreClkSlow,
    // Bundle stream
    output reg  [7:0] loadData,
    output reg        loadValid
);

    // Serial clock half period, rounded up so the rate never passes 12 MHz
    localparam integer SCK_HALF = (`BSFL_CLK_KHZ + 2 * `BSFL_SCK_MAX_KHZ - 1)
                                  / (2 * `BSFL_SCK_MAX_KHZ);
    localparam integer SETTLE_CYC = `BSFL_SETTLE_US * `BSFL_CLK_KHZ / 1000;
    localparam integer CW = 24;
    localparam [7:0] LAST_IDX = 8'h04 + LOAD_BYTES[7:0] - 8'h01;

    // Boot states
    localparam [2:0] ST_INIT  = 3'h0;
    localparam [2:0] ST_POWER = 3'h1;
    localparam [2:0] ST_HOLD  = 3'h2;
    localparam [2:0] ST_LOAD  = 3'h3;
    localparam [2:0] ST_XFER  = 3'h4;
    localparam [2:0] ST_CHECK = 3'h5;
    localparam [2:0] ST_RETRY = 3'h6;
    localparam [2:0] ST_DONE  = 3'h7;

    // Strap level to range index 0..9
    function [3:0] level_of;
        input [7:0] code;
        begin
            level_of = {3'h0, code > `BSFL_THR_0} + {3'h0, code > `BSFL_THR_1}
                     + {3'h0, code > `BSFL_THR_2} + {3'h0, code > `BSFL_THR_3}
                     + {3'h0, code > `BSFL_THR_4} + {3'h0, code > `BSFL_THR_5}
                     + {3'h0, code > `BSFL_THR_6} + {3'h0, code > `BSFL_THR_7}
                     + {3'h0, code > `BSFL_THR_8};
        end
    endfunction

    // Two-bit address level: ground, two divider bands, supply
    function [1:0] addr_level;
        input [3:0] lvl;
        begin
            if (lvl < 4'h2)
                addr_level = 2'h0;
            else if (lvl < 4'h4)
                addr_level = 2'h1;
            else if (lvl < 4'h6)
                addr_level = 2'h2;
            else
                addr_level = 2'h3;
        end
    endfunction

    // Boot strap table: {mode, config}
    function [5:0] boot_decode;
        input       dataHigh;
        input [3:0] lvl;
        begin
            if (dataHigh) begin
                case (lvl)
                    4'h2:    boot_decode = {`BSFL_DB_WAIT_INT, `BSFL_CFG_SAFE};
                    4'h3:    boot_decode = {`BSFL_DB_CTRL_INT, `BSFL_CFG_INF_WAIT};
                    4'h4:    boot_decode = {`BSFL_DB_WAIT_EXT, `BSFL_CFG_SAFE};
                    4'h5:    boot_decode = {`BSFL_DB_CTRL_EXT, `BSFL_CFG_INF_WAIT};
                    4'h0,
                    4'h1:    boot_decode = {`BSFL_DB_NO_RESPONSE, `BSFL_CFG_SAFE};
                    default: boot_decode = {`BSFL_DB_NO_WAIT, `BSFL_CFG_SAFE};
                endcase
            end else begin
                case (lvl)
                    4'h2:    boot_decode = {`BSFL_DB_NO_RESPONSE, `BSFL_CFG_2};
                    4'h3:    boot_decode = {`BSFL_DB_CTRL_INT, `BSFL_CFG_INF_WAIT};
                    4'h4:    boot_decode = {`BSFL_DB_NO_WAIT, `BSFL_CFG_3};
                    4'h5:    boot_decode = {`BSFL_DB_CTRL_EXT, `BSFL_CFG_INF_WAIT};
                    4'h6:    boot_decode = {`BSFL_DB_NO_RESPONSE, `BSFL_CFG_4};
                    4'h7:    boot_decode = {`BSFL_DB_NO_WAIT, `BSFL_CFG_RESERVED};
                    4'h8:    boot_decode = {`BSFL_DB_NO_RESPONSE, `BSFL_CFG_RESERVED};
                    4'h9:    boot_decode = {`BSFL_DB_NO_WAIT, `BSFL_CFG_5};
                    // Below the lowest band is read as the first band
                    default: boot_decode = {`BSFL_DB_NO_RESPONSE, `BSFL_CFG_1};
                endcase
            end
        end
    endfunction

    // Outgoing byte for each position of the read sequence
    function [7:0] tx_of;
        input [7:0] idx;
        begin
            if (idx == 8'h00)
                tx_of = `BSFL_CMD_READ;
            else if (idx == `BSFL_IDX_ADDR_HI)
                tx_of = 8'h00;
            else if (idx == `BSFL_IDX_ADDR_MID)
                tx_of = {FLASH_SECTOR, 4'h0};
            else if (idx == `BSFL_IDX_ADDR_LO)
                tx_of = 8'h00;
            else
                tx_of = 8'h00;
        end
    endfunction

    // Async inputs: {addr, boot, aux, bus, lowPower}
    wire [19:0] asyncIn = {addrStrapLevel, bootStrapLevel, auxSupplyIn, cableBusIn, lowPowerReq};
    reg  [19:0] in_meta_ff;
    reg  [19:0] in_sync_ff;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_meta_ff <= 20'h00000;
            in_sync_ff <= 20'h00000;
        end else begin
            in_meta_ff <= asyncIn;
            in_sync_ff <= in_meta_ff;
        end
    end

    wire [7:0] addrLvlSync = in_sync_ff[19:12];
    wire [7:0] bootLvlSync = in_sync_ff[11:4];
    wire       auxSync     = in_sync_ff[3];
    wire [1:0] busSync     = in_sync_ff[2:1];
    wire       lowPwrSync  = in_sync_ff[0];

    // Dead-battery policy only counts when the cable bus is the sole supply
    wire busOnly = !auxSync && (busSync != 2'h0);

    // SPI engine hookup
    wire       spiBusy;
    wire       spiDone;
    wire [7:0] spiRx;
    wire       dataStrap;
    reg        spiStart_ff;
    reg  [7:0] spiTx_ff;
    reg        spiKeep_ff;

    bsfl_spi_master #(
        .HALF         (SCK_HALF)
    ) u_spi (
        .clk          (clk),
        .resetn       (resetn),
        .start        (spiStart_ff),
        .txByte       (spiTx_ff),
        .keepSel      (spiKeep_ff),
        .busy         (spiBusy),
        .done         (spiDone),
        .rxByte       (spiRx),
        .misoSync     (dataStrap),
        .flashClk     (flashClk),
        .flashCsN     (flashCsN),
        .flashDataOut (flashDataOut),
        .flashDataIn  (flashDataIn)
    );

    reg  [2:0]    state_ff;
    reg  [CW-1:0] cnt_ff;
    reg  [7:0]    idx_ff;
    reg           sigBad_ff;
    reg  [1:0]    swSel_ff;

    wire [3:0] addrLvl  = level_of(addrLvlSync);
    wire [3:0] bootLvl  = level_of(bootLvlSync);
    wire [5:0] bootSel  = boot_decode(dataStrap, bootLvl);
    wire [7:0] nextIdx  = idx_ff + 8'h01;
    wire       ctrlWait = (deadBattMode == `BSFL_DB_CTRL_INT) || (deadBattMode == `BSFL_DB_CTRL_EXT);

    // Boot sequencer; reset puts every result in its initial state
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff        <= ST_INIT;
            cnt_ff          <= {CW{1'b0}};
            idx_ff          <= 8'h00;
            sigBad_ff       <= 1'b0;
            swSel_ff        <= 2'h0;
            spiStart_ff     <= 1'b0;
            spiTx_ff        <= 8'h00;
            spiKeep_ff      <= 1'b0;
            portOneAddrCode <= 3'h0;
            portTwoAddrCode <= 3'h0;
            deadBattMode    <= `BSFL_DB_NO_RESPONSE;
            defaultConfig   <= `BSFL_CFG_SAFE;
            bootDone        <= 1'b0;
            configLoaded    <= 1'b0;
            loadFail        <= 1'b0;
            portsEnable     <= 1'b0;
            legacySinkEn    <= 1'b0;
            intSwitchEn     <= 2'h0;
            extSwitchEn     <= 2'h0;
            coreClkSlow     <= 1'b0;
            loadData        <= 8'h00;
            loadValid       <= 1'b0;
        end else begin
            spiStart_ff <= 1'b0;
            loadValid   <= 1'b0;
            case (state_ff)
                // Let straps and the data line pull settle, then latch once
                ST_INIT: begin
                    if (cnt_ff == SETTLE_CYC[CW-1:0]) begin
                        cnt_ff          <= {CW{1'b0}};
                        portOneAddrCode <= {`BSFL_ADDR_PORT_ONE, addr_level(addrLvl)};
                        portTwoAddrCode <= {`BSFL_ADDR_PORT_TWO, addr_level(addrLvl)};
                        deadBattMode    <= bootSel[5:3];
                        defaultConfig   <= bootSel[2:0];
                        state_ff        <= ST_POWER;
                    end else begin
                        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                // Pick the dead-battery action for the powered port
                ST_POWER: begin
                    if (!busOnly) begin
                        state_ff <= ST_LOAD;
                    end else begin
                        case (deadBattMode)
                            `BSFL_DB_WAIT_INT: begin
                                intSwitchEn <= busSync;
                                state_ff    <= ST_HOLD;
                            end
                            `BSFL_DB_WAIT_EXT: begin
                                extSwitchEn <= busSync;
                                state_ff    <= ST_HOLD;
                            end
                            `BSFL_DB_CTRL_INT: begin
                                intSwitchEn <= busSync;
                                state_ff    <= ST_LOAD;
                            end
                            `BSFL_DB_CTRL_EXT: begin
                                extSwitchEn <= busSync;
                                state_ff    <= ST_LOAD;
                            end
                            `BSFL_DB_NO_WAIT: begin
                                state_ff <= ST_LOAD;
                            end
                            default: begin
                                state_ff <= ST_HOLD;
                            end
                        endcase
                    end
                end
                // No start-up and no loading until the aux supply shows up
                ST_HOLD: begin
                    if (auxSync)
                        state_ff <= ST_LOAD;
                end
                // Open a read: command byte goes out with chip select
                ST_LOAD: begin
                    idx_ff      <= 8'h00;
                    sigBad_ff   <= 1'b0;
                    spiStart_ff <= 1'b1;
                    spiTx_ff    <= tx_of(8'h00);
                    spiKeep_ff  <= 1'b1;
                    state_ff    <= ST_XFER;
                end
                // Command, address, then stream the bundle bytes out
                ST_XFER: begin
                    if (spiDone) begin
                        if (idx_ff >= `BSFL_IDX_SIG) begin
                            loadData  <= spiRx;
                            loadValid <= 1'b1;
                        end
                        if ((idx_ff == `BSFL_IDX_SIG) && (spiRx != BUNDLE_SIG))
                            sigBad_ff <= 1'b1;
                        if (idx_ff == `BSFL_IDX_SWITCH) begin
                            swSel_ff <= {spiRx[`BSFL_SW_EXT_BIT], spiRx[`BSFL_SW_INT_BIT]};
                        end
                        if (idx_ff == LAST_IDX) begin
                            state_ff <= ST_CHECK;
                        end else begin
                            idx_ff      <= nextIdx;
                            spiStart_ff <= 1'b1;
                            spiTx_ff    <= tx_of(nextIdx);
                            spiKeep_ff  <= (nextIdx != LAST_IDX);
                        end
                    end
                end
                // Accept the bundle or fall back to the strapped default
                ST_CHECK: begin
                    if (!sigBad_ff) begin
                        configLoaded <= 1'b1;
                        loadFail     <= 1'b0;
                        portsEnable  <= 1'b1;
                        legacySinkEn <= 1'b0;
                        bootDone     <= 1'b1;
                        state_ff     <= ST_DONE;
                        if (busOnly && (deadBattMode == `BSFL_DB_NO_WAIT)) begin
                            intSwitchEn <= busSync & {2{swSel_ff[0]}};
                            extSwitchEn <= busSync & {2{swSel_ff[1]}};
                        end
                    end else begin
                        loadFail <= 1'b1;
                        if ((busOnly && ctrlWait) || (defaultConfig == `BSFL_CFG_INF_WAIT)) begin
                            // Keep trying; bounded gap keeps the flash bus quiet
                            state_ff <= ST_RETRY;
                        end else begin
                            bootDone <= 1'b1;
                            state_ff <= ST_DONE;
                            if (defaultConfig == `BSFL_CFG_SAFE) begin
                                portsEnable  <= 1'b0;
                                legacySinkEn <= busOnly;
                            end else begin
                                portsEnable <= 1'b1;
                            end
                        end
                    end
                end
                ST_RETRY: begin
                    if (cnt_ff == RETRY_CYCLES[CW-1:0]) begin
                        cnt_ff   <= {CW{1'b0}};
                        state_ff <= ST_LOAD;
                    end else begin
                        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                // Booted: only the core clock choice moves from here on
                default: begin
                    coreClkSlow <= lowPwrSync;
                end
            endcase
        end
    end

endmodule // bsfl_boot_loader

/* File: dv/bsfl_properties.sv */
/* Pin checker of the boot loader.
   Bound into bsfl_boot_loader; sees its ports only. */
`include "bsfl_regs.vh"
module bsfl_checker (
    // Clock, reset, flash pins
    input logic       clk,
    input logic       resetn,
    input logic       flashClk,
    input logic       flashCsN,
    input logic       flashDataOut,
    // Boot results
    input logic [2:0] portOneAddrCode,
    input logic [2:0] portTwoAddrCode,
    input logic [2:0] defaultConfig,
    input logic       bootDone,
    input logic       loadFail,
    input logic       portsEnable,
    input logic       coreClkSlow
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Link shape; a high phase of 11+ cycles keeps the rate under 12 MHz
    property p_idle; flashCsN |-> !flashClk; endproperty
    a_idle: assert property (p_idle) else $error("clk runs idle");
    property p_first; $fell(flashCsN) |-> !flashClk && !flashDataOut; endproperty
    a_first: assert property (p_first) else $error("bad first bit");
    property p_shift; !flashCsN && $changed(flashDataOut) |-> !flashClk; endproperty
    a_shift: assert property (p_shift) else $error("data moved high");
    property p_high; $rose(flashClk) |-> (flashClk && !flashCsN)[*8] ##1 flashClk[*3]; endproperty
    a_high: assert property (p_high) else $error("short clk high");
    // Latched straps, slow clock only after boot, fall-back outcome
    property p_addr; bootDone |-> portTwoAddrCode == {1'b1, portOneAddrCode[1:0]}; endproperty
    a_addr: assert property (p_addr) else $error("port codes differ");
    property p_hold; bootDone && $past(bootDone) |-> $stable({portOneAddrCode, defaultConfig}); endproperty
    a_hold: assert property (p_hold) else $error("strap moved");
    property p_slow; coreClkSlow |-> bootDone; endproperty
    a_slow: assert property (p_slow) else $error("slow clk early");
    property p_safe; loadFail && defaultConfig == `BSFL_CFG_SAFE |-> !portsEnable; endproperty
    a_safe: assert property (p_safe) else $error("safe ports on");
endmodule // bsfl_checker

bind bsfl_boot_loader bsfl_checker u_chk (.clk, .resetn, .flashClk, .flashCsN, .flashDataOut,
    .portOneAddrCode, .portTwoAddrCode, .defaultConfig, .bootDone, .loadFail, .portsEnable, .coreClkSlow);

/* File: dv/bsfl_flash_model.sv */
/* Serial flash model: mode 0 read that replies with a bundle.
   Assumes the loader drives select, clock and command. */
module bsfl_flash_model #(
    parameter logic [7:0] SIG = 8'ha5   // arbitrary marker value
) (
    // Flash pins
    input  logic        flashClk,
    input  logic        flashCsN,
    input  logic        flashDataOut,
    output logic        flashDataIn,
    // Bench controls
    input  logic        pullHigh,
    input  logic        sigOk,
    input  logic [7:0]  swByte,
    output logic [31:0] cmdWord
);
    timeunit 1ns;
    timeprecision 100ps;
    int   bitCnt = 0;
    logic outBit = 1'b1;
    // Bit n of the reply; the line floats during the command
    function automatic logic bitAt(int n);
        logic [7:0] b;
        b = n < 32 ? {8{pullHigh}} : n < 40 ? (sigOk ? SIG : 8'h00) : n < 48 ? swByte : 8'(n) ^ 8'h5a;
        return b[7 - n % 8];
    endfunction
    // Sample on rise; the first 32 bits form the command word
    always @(posedge flashClk) if (!flashCsN) begin
        if (bitCnt < 32) cmdWord <= {cmdWord[30:0], flashDataOut};
        bitCnt <= bitCnt + 1;
    end
    // Next bit with select or after the fall
    always @(negedge flashClk or negedge flashCsN) outBit <= bitAt(bitCnt);
    always @(posedge flashCsN) bitCnt <= 0;
    // Released line goes to the strap resistor level
    assign flashDataIn = flashCsN ? pullHigh : outBit;
endmodule // bsfl_flash_model

/* File: dv/bsfl_boot_loader_test.sv */
/* Bench of the boot loader: strap decode, dead-battery policy, flash read.
   Assumes the flash model and checker are compiled before it. */
module bsfl_boot_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, resetn = 0, auxSupplyIn, lowPowerReq, sigOk = 1, pullHigh;
    logic flashClk, flashCsN, flashDataOut, flashDataIn, bootDone, configLoaded, loadFail;
    logic portsEnable, legacySinkEn, coreClkSlow, loadValid;
    logic [7:0] addrStrapLevel, bootStrapLevel, loadData, swByte = 0;
    logic [1:0] cableBusIn, intSwitchEn, extSwitchEn;
    logic [2:0] portOneAddrCode, portTwoAddrCode, deadBattMode, defaultConfig;
    logic [31:0] cmdWord;
    int errors = 0, compares = 0, nValid;
    // Rows: data strap, boot level, mode, config
    logic [14:0] tbl [15] = '{15'h4400, 15'h4f08, 15'h55d9, 15'h5c10, 15'h62a1, 15'h7028, 15'h0902,
        15'h0f03, 15'h15d9, 15'h1c2c, 15'h22a1, 15'h2905, 15'h2faf, 15'h35c7, 15'h3cae};
    logic [7:0] addrTbl [4] = '{8'h00, 8'h3c, 8'h70, 8'hff};
    bsfl_boot_loader #(.LOAD_BYTES(2), .FLASH_SECTOR(4'h2), .RETRY_CYCLES(20)) dut (.clk, .resetn,
        .addrStrapLevel, .bootStrapLevel, .auxSupplyIn, .cableBusIn, .lowPowerReq, .flashClk,
        .flashCsN, .flashDataOut, .flashDataIn, .portOneAddrCode, .portTwoAddrCode, .deadBattMode,
        .defaultConfig, .bootDone, .configLoaded, .loadFail, .portsEnable, .legacySinkEn,
        .intSwitchEn, .extSwitchEn, .coreClkSlow, .loadData, .loadValid);
    bsfl_flash_model flash (.flashClk, .flashCsN, .flashDataOut, .flashDataIn, .pullHigh, .sigOk,
        .swByte, .cmdWord);
    // 250 MHz core clock; count streamed bytes
    always #2 clk = ~clk;
    always @(posedge clk) if (loadValid) nValid++;
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Power-on reset with fresh strap and supply levels
    task automatic boot(logic [7:0] lvl, logic strap, logic aux, logic [1:0] bus);
        resetn = 0;
        {bootStrapLevel, pullHigh, auxSupplyIn, cableBusIn, lowPowerReq, nValid} = {lvl, strap, aux, bus, 1'b0, 32'h0};
        tick(10);
        resetn = 1;
    endtask
    // Bounded wait for the end of boot
    task automatic waitDone;
        for (int i = 0; i < 20000 && bootDone !== 1'b1; i++) tick(1);
        if (bootDone !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask
    initial begin
        for (int i = 0; i < 15; i++) begin
            addrStrapLevel = addrTbl[i % 4];
            boot(tbl[i][13:6], tbl[i][14], 1, 2'b00);
            waitDone();
            {addrStrapLevel, bootStrapLevel} = ~{addrStrapLevel, bootStrapLevel};
            tick(10);
            chk(portOneAddrCode, i % 4);
            chk(portTwoAddrCode, 4 + i % 4);
            chk({deadBattMode, defaultConfig}, tbl[i][5:0]);
            chk({configLoaded, intSwitchEn, extSwitchEn, nValid[3:0]}, 9'h102);
            chk(cmdWord, 32'h03002000);
        end
        // Bus power only: hold-offs, retries, bundle switches, fall-back
        boot(8'h10, 1, 0, 2'b01);
        tick(3000);
        chk({bootDone, flashCsN, intSwitchEn, extSwitchEn}, 6'h10);
        auxSupplyIn = 1;
        waitDone();
        chk(configLoaded, 1);
        boot(8'h3c, 1, 0, 2'b01);
        tick(3000);
        chk({bootDone, flashCsN, intSwitchEn}, 4'h5);
        sigOk = 0;
        boot(8'h8a, 1, 0, 2'b10);
        tick(5000);
        chk({bootDone, extSwitchEn}, 3'h2);
        sigOk = 1;
        waitDone();
        chk(configLoaded, 1);
        swByte = 8'h01;
        boot(8'hc0, 1, 0, 2'b10);
        waitDone();
        chk({configLoaded, portsEnable, intSwitchEn, extSwitchEn, loadData}, 14'h3801);
        sigOk = 0;
        boot(8'hc0, 1, 0, 2'b01);
        waitDone();
        chk({loadFail, portsEnable, legacySinkEn}, 3'h5);
        lowPowerReq = 1;
        tick(6);
        chk(coreClkSlow, 1);
        print_verdict();
    end
endmodule // bsfl_boot_loader_test
